// *** rtl/cpm_clock_pin_mux.sv ***
// Operation
// - with the mode pin high, the external clock on the oscillator out pin is the input clock and the oscillator is not driven.
// - with the mode pin low, the internal oscillator drives the out pin from the in pin across a crystal.
// - a control bit chooses whether the input clock feeds the core directly or the pll reference.
// - the clock monitor pin shows disabled, master, peripheral bus, oscillator, prescaler or postscaler clock per the select register.
// - address and bus control lines are tri-stated while the bus is idle when the drive bit selects that.
// - the six port a pins come out of reset in address function until software makes them gpio.
// - the address function on port a does not exist here, so port a drives only as gpio.
// - each port a pin has its own direction bit in gpio function.
// - clearing bit n of the port a pullup register turns off pin n's pullup.
// - the four port b pins come out of reset in gpio function.
// - clearing bit n of the port b pullup register turns off pin n's pullup.
// - clearing a port b peripheral enable bit hands the pin to address or clock function per the select register.
`timescale 1ns/10ps
`default_nettype none
module cpm_clock_pin_mux
    import cpm_pkg::*;
(
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // oscillator pins and mode strap
    input wire logic clock_source_select_pin,
    input wire logic oscillator_in_pin,
    input wire logic oscillator_out_pin_i,
    output logic oscillator_out_pin_o,
    output logic oscillator_out_pin_oe,
    // clock routing towards core and pll
    output logic input_clock,
    output logic core_clock_direct,
    output logic pll_ref_clock,
    output logic core_from_pll,
    // internal clocks offered to the monitor pin
    input wire logic master_system_clock,
    input wire logic peripheral_bus_clock,
    input wire logic prescaler_clock,
    input wire logic postscaler_clock,
    output logic clock_monitor_out,
    output logic clock_monitor_out_oe,
    // external memory interface side
    input wire logic emi_bus_active,
    input wire logic [cpm_pkg::CPM_PB_W-1:0] emi_addr_hi,
    input wire logic [3:0] emi_ctrl,
    output logic [3:0] emi_ctrl_o,
    output logic [3:0] emi_ctrl_oe,
    // port a pins
    input wire logic [cpm_pkg::CPM_PA_W-1:0] port_a_i,
    output logic [cpm_pkg::CPM_PA_W-1:0] port_a_o,
    output logic [cpm_pkg::CPM_PA_W-1:0] port_a_oe,
    output logic [cpm_pkg::CPM_PA_W-1:0] port_a_pullup_on,
    // port b pins
    input wire logic [cpm_pkg::CPM_PB_W-1:0] port_b_i,
    output logic [cpm_pkg::CPM_PB_W-1:0] port_b_o,
    output logic [cpm_pkg::CPM_PB_W-1:0] port_b_oe,
    output logic [cpm_pkg::CPM_PB_W-1:0] port_b_pullup_on
);
    import cpm_pkg::*;

    // word address compare, shared by write and read decode
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        reg_hit = (a[7:2] == off[7:2]);
    endfunction

    // software state
    logic core_from_pll_r;
    logic [CPM_CLK_SEL_W-1:0] clk_sel_r;
    logic pb_clk_fn_r;
    logic drive_r;
    logic [CPM_PA_W-1:0] pa_data_r, pa_dir_r, pa_pullup_r, pa_gpio_en_r;
    logic [CPM_PB_W-1:0] pb_data_r, pb_dir_r, pb_pullup_r, pb_periph_en_r;

    // bus state
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;

    // pin synchronisers: first stage is read only by the second
    logic mode_s1_r, mode_s2_r;
    logic osc_in_s1_r, osc_in_s2_r;
    logic ext_s1_r, ext_s2_r;
    logic [3:0] clk_s1_r, clk_s2_r;
    logic [CPM_PA_W-1:0] pa_s1_r, pa_s2_r;
    logic [CPM_PB_W-1:0] pb_s1_r, pb_s2_r;

    // registered pin outputs
    logic in_clk_r, osc_o_r, osc_oe_r;
    logic mon_r, mon_oe_r;
    logic [3:0] ctrl_o_r, ctrl_oe_r;
    logic [CPM_PA_W-1:0] pa_o_r, pa_oe_r;
    logic [CPM_PB_W-1:0] pb_o_r, pb_oe_r;

    // address phase decode
    wire addr_phase = hsel & htrans[1] & hready;
    wire take_wr = addr_phase & hwrite;
    wire take_rd = addr_phase & ~hwrite;
    wire [7:0] a_ad = haddr[7:0];
    wire [7:0] w_ad = wr_addr_r;
    wire do_wr = wr_pend_r & hready;

    // write strobes, decoded in the data phase
    wire wr_clk_ctrl = do_wr & reg_hit(w_ad, CPM_CLK_CTRL_OFF);
    wire wr_clk_sel = do_wr & reg_hit(w_ad, CPM_CLK_OUT_SEL_OFF);
    wire wr_bus_ctrl = do_wr & reg_hit(w_ad, CPM_BUS_CTRL_OFF);
    wire wr_pa_data = do_wr & reg_hit(w_ad, CPM_PA_DATA_OFF);
    wire wr_pa_dir = do_wr & reg_hit(w_ad, CPM_PA_DIR_OFF);
    wire wr_pa_pull = do_wr & reg_hit(w_ad, CPM_PA_PULLUP_OFF);
    wire wr_pa_gpio = do_wr & reg_hit(w_ad, CPM_PA_GPIO_EN_OFF);
    wire wr_pb_data = do_wr & reg_hit(w_ad, CPM_PB_DATA_OFF);
    wire wr_pb_dir = do_wr & reg_hit(w_ad, CPM_PB_DIR_OFF);
    wire wr_pb_pull = do_wr & reg_hit(w_ad, CPM_PB_PULLUP_OFF);
    wire wr_pb_per = do_wr & reg_hit(w_ad, CPM_PB_PERIPH_EN_OFF);

    // read mux, unmapped words read zero
    wire [31:0] rd_clk_ctrl = {30'h0, mode_s2_r, core_from_pll_r};
    wire [31:0] rd_clk_sel = {27'h0, pb_clk_fn_r, 1'h0, clk_sel_r};
    wire [31:0] rd_bus = {31'h0, drive_r};
    wire [31:0] rd_mux =
        reg_hit(a_ad, CPM_CLK_CTRL_OFF) ? rd_clk_ctrl :
        reg_hit(a_ad, CPM_CLK_OUT_SEL_OFF) ? rd_clk_sel :
        reg_hit(a_ad, CPM_BUS_CTRL_OFF) ? rd_bus :
        reg_hit(a_ad, CPM_PA_DATA_OFF) ? {26'h0, pa_data_r} :
        reg_hit(a_ad, CPM_PA_DIR_OFF) ? {26'h0, pa_dir_r} :
        reg_hit(a_ad, CPM_PA_PULLUP_OFF) ? {26'h0, pa_pullup_r} :
        reg_hit(a_ad, CPM_PA_GPIO_EN_OFF) ? {26'h0, pa_gpio_en_r} :
        reg_hit(a_ad, CPM_PA_PIN_OFF) ? {26'h0, pa_s2_r} :
        reg_hit(a_ad, CPM_PB_DATA_OFF) ? {28'h0, pb_data_r} :
        reg_hit(a_ad, CPM_PB_DIR_OFF) ? {28'h0, pb_dir_r} :
        reg_hit(a_ad, CPM_PB_PULLUP_OFF) ? {28'h0, pb_pullup_r} :
        reg_hit(a_ad, CPM_PB_PERIPH_EN_OFF) ? {28'h0, pb_periph_en_r} :
        reg_hit(a_ad, CPM_PB_PIN_OFF) ? {28'h0, pb_s2_r} :
        32'h0;

    // bus slave: zero wait states, read data registered into the data phase
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_pend_r <= 1'h0;
            wr_addr_r <= 8'h0;
            hrdata_r <= 32'h0;
        end else if (ce) begin
            if (hready) begin
                wr_pend_r <= take_wr;
                wr_addr_r <= a_ad;
            end
            if (take_rd) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // clock and bus control registers
    always_ff @(posedge clock) begin
        if (rst) begin
            core_from_pll_r <= 1'h0;
            clk_sel_r <= CPM_CLK_OFF;
            pb_clk_fn_r <= 1'h0;
            drive_r <= CPM_DRIVE_RST;
        end else if (ce) begin
            if (wr_clk_ctrl) begin
                core_from_pll_r <= hwdata[CPM_CORE_PLL_BIT];
            end
            if (wr_clk_sel) begin
                clk_sel_r <= hwdata[CPM_CLK_SEL_LSB +: CPM_CLK_SEL_W];
                pb_clk_fn_r <= hwdata[CPM_PB_CLK_FN_BIT];
            end
            if (wr_bus_ctrl) begin
                drive_r <= hwdata[CPM_DRIVE_BIT];
            end
        end
    end

    // port a registers; address function is the reset state
    always_ff @(posedge clock) begin
        if (rst) begin
            pa_data_r <= '0;
            pa_dir_r <= '0;
            pa_pullup_r <= CPM_PA_PULLUP_RST;
            pa_gpio_en_r <= CPM_PA_GPIO_EN_RST;
        end else if (ce) begin
            if (wr_pa_data) begin
                pa_data_r <= hwdata[CPM_PA_W-1:0];
            end
            if (wr_pa_dir) begin
                pa_dir_r <= hwdata[CPM_PA_W-1:0];
            end
            if (wr_pa_pull) begin
                pa_pullup_r <= hwdata[CPM_PA_W-1:0];
            end
            if (wr_pa_gpio) begin
                pa_gpio_en_r <= hwdata[CPM_PA_W-1:0];
            end
        end
    end

    // port b registers; gpio function is the reset state
    always_ff @(posedge clock) begin
        if (rst) begin
            pb_data_r <= '0;
            pb_dir_r <= '0;
            pb_pullup_r <= CPM_PB_PULLUP_RST;
            pb_periph_en_r <= CPM_PB_PERIPH_EN_RST;
        end else if (ce) begin
            if (wr_pb_data) begin
                pb_data_r <= hwdata[CPM_PB_W-1:0];
            end
            if (wr_pb_dir) begin
                pb_dir_r <= hwdata[CPM_PB_W-1:0];
            end
            if (wr_pb_pull) begin
                pb_pullup_r <= hwdata[CPM_PB_W-1:0];
            end
            if (wr_pb_per) begin
                pb_periph_en_r <= hwdata[CPM_PB_W-1:0];
            end
        end
    end

    // two-flop synchronisers for every pin and foreign clock
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_s1_r <= 1'h0;
            mode_s2_r <= 1'h0;
            osc_in_s1_r <= 1'h0;
            osc_in_s2_r <= 1'h0;
            ext_s1_r <= 1'h0;
            ext_s2_r <= 1'h0;
            clk_s1_r <= 4'h0;
            clk_s2_r <= 4'h0;
            pa_s1_r <= '0;
            pa_s2_r <= '0;
            pb_s1_r <= '0;
            pb_s2_r <= '0;
        end else if (ce) begin
            mode_s1_r <= clock_source_select_pin;
            mode_s2_r <= mode_s1_r;
            osc_in_s1_r <= oscillator_in_pin;
            osc_in_s2_r <= osc_in_s1_r;
            ext_s1_r <= oscillator_out_pin_i;
            ext_s2_r <= ext_s1_r;
            clk_s1_r <= {postscaler_clock, prescaler_clock,
                         peripheral_bus_clock, master_system_clock};
            clk_s2_r <= clk_s1_r;
            pa_s1_r <= port_a_i;
            pa_s2_r <= pa_s1_r;
            pb_s1_r <= port_b_i;
            pb_s2_r <= pb_s1_r;
        end
    end

    // oscillator: the amplifier drives only in crystal mode, else the
    // out pin turns input so an external source cannot fight it
    wire osc_drive = ~mode_s2_r;
    wire in_clk_nxt = mode_s2_r ? ext_s2_r : osc_in_s2_r;

    // clock monitor source selection, undefined codes read as off
    cpm_clk_sel_e sel_e;
    assign sel_e = cpm_clk_sel_e'(clk_sel_r);
    logic mon_nxt;
    always_comb begin
        case (sel_e)
            CPM_CLK_MASTER: mon_nxt = clk_s2_r[0];
            CPM_CLK_PERIPH: mon_nxt = clk_s2_r[1];
            CPM_CLK_OSC: mon_nxt = in_clk_r;
            CPM_CLK_PRESCALE: mon_nxt = clk_s2_r[2];
            CPM_CLK_POSTSCALE: mon_nxt = clk_s2_r[3];
            default: mon_nxt = 1'h0;
        endcase
    end
    wire mon_oe_nxt = (clk_sel_r != CPM_CLK_OFF) &&
                      (clk_sel_r <= CPM_CLK_POSTSCALE);

    // external bus keeps driving when idle only if the drive bit is set
    wire emi_drive = emi_bus_active | drive_r;

    // port a: the address function has no pads here, so it never drives
    wire [CPM_PA_W-1:0] pa_oe_nxt = pa_gpio_en_r & pa_dir_r;

    // port b per-pin function selection
    logic [CPM_PB_W-1:0] pb_o_nxt, pb_oe_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < CPM_PB_W; gi++) begin : g_pb
            wire alt = ~pb_periph_en_r[gi];
            wire alt_o = pb_clk_fn_r ? mon_nxt : emi_addr_hi[gi];
            wire alt_oe = pb_clk_fn_r ? mon_oe_nxt : emi_drive;
            assign pb_o_nxt[gi] = alt ? alt_o : pb_data_r[gi];
            assign pb_oe_nxt[gi] = alt ? alt_oe : pb_dir_r[gi];
        end
    endgenerate

    // registered pin drivers, all off while in reset
    always_ff @(posedge clock) begin
        if (rst) begin
            in_clk_r <= 1'h0;
            osc_o_r <= 1'h0;
            osc_oe_r <= 1'h0;
            mon_r <= 1'h0;
            mon_oe_r <= 1'h0;
            ctrl_o_r <= 4'h0;
            ctrl_oe_r <= 4'h0;
            pa_o_r <= '0;
            pa_oe_r <= '0;
            pb_o_r <= '0;
            pb_oe_r <= '0;
        end else if (ce) begin
            in_clk_r <= in_clk_nxt;
            osc_o_r <= ~osc_in_s2_r;
            osc_oe_r <= osc_drive;
            mon_r <= mon_nxt;
            mon_oe_r <= mon_oe_nxt;
            ctrl_o_r <= emi_ctrl;
            ctrl_oe_r <= {4{emi_drive}};
            pa_o_r <= pa_data_r;
            pa_oe_r <= pa_oe_nxt;
            pb_o_r <= pb_o_nxt;
            pb_oe_r <= pb_oe_nxt;
        end
    end

    // outputs; pullups follow their registers directly
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign hrdata = hrdata_r;
    assign oscillator_out_pin_o = osc_o_r;
    assign oscillator_out_pin_oe = osc_oe_r;
    assign input_clock = in_clk_r;
    assign core_from_pll = core_from_pll_r;
    assign core_clock_direct = in_clk_r & ~core_from_pll_r;
    assign pll_ref_clock = in_clk_r & core_from_pll_r;
    assign clock_monitor_out = mon_r;
    assign clock_monitor_out_oe = mon_oe_r;
    assign emi_ctrl_o = ctrl_o_r;
    assign emi_ctrl_oe = ctrl_oe_r;
    assign port_a_o = pa_o_r;
    assign port_a_oe = pa_oe_r;
    assign port_a_pullup_on = pa_pullup_r;
    assign port_b_o = pb_o_r;
    assign port_b_oe = pb_oe_r;
    assign port_b_pullup_on = pb_pullup_r;

    // hsize is accepted but only whole-word transfers are expected
    wire unused_ok = &{1'b0, hsize, haddr[31:8]};
endmodule
`default_nettype wire

// *** rtl/cpm_pkg.sv ***
package cpm_pkg;
    // register byte offsets, one aligned word each
    localparam logic [7:0] CPM_CLK_CTRL_OFF = 8'h00;
    localparam logic [7:0] CPM_CLK_OUT_SEL_OFF = 8'h04;
    localparam logic [7:0] CPM_BUS_CTRL_OFF = 8'h08;
    localparam logic [7:0] CPM_PA_DATA_OFF = 8'h0c;
    localparam logic [7:0] CPM_PA_DIR_OFF = 8'h10;
    localparam logic [7:0] CPM_PA_PULLUP_OFF = 8'h14;
    localparam logic [7:0] CPM_PA_GPIO_EN_OFF = 8'h18;
    localparam logic [7:0] CPM_PA_PIN_OFF = 8'h1c;
    localparam logic [7:0] CPM_PB_DATA_OFF = 8'h20;
    localparam logic [7:0] CPM_PB_DIR_OFF = 8'h24;
    localparam logic [7:0] CPM_PB_PULLUP_OFF = 8'h28;
    localparam logic [7:0] CPM_PB_PERIPH_EN_OFF = 8'h2c;
    localparam logic [7:0] CPM_PB_PIN_OFF = 8'h30;

    // pin counts
    localparam int CPM_PA_W = 6;
    localparam int CPM_PB_W = 4;

    // field positions
    localparam int CPM_CORE_PLL_BIT = 0;
    localparam int CPM_MODE_STAT_BIT = 1;
    localparam int CPM_CLK_SEL_LSB = 0;
    localparam int CPM_CLK_SEL_W = 3;
    localparam int CPM_PB_CLK_FN_BIT = 4;
    localparam int CPM_DRIVE_BIT = 0;

    // reset values
    localparam logic [CPM_PA_W-1:0] CPM_PA_PULLUP_RST = 6'h3f;
    localparam logic [CPM_PA_W-1:0] CPM_PA_GPIO_EN_RST = 6'h00;
    localparam logic [CPM_PB_W-1:0] CPM_PB_PULLUP_RST = 4'hf;
    localparam logic [CPM_PB_W-1:0] CPM_PB_PERIPH_EN_RST = 4'hf;
    localparam logic CPM_DRIVE_RST = 1'h0;

    // clock monitor source codes
    typedef enum logic [2:0] {
        CPM_CLK_OFF = 3'h0,
        CPM_CLK_MASTER = 3'h1,
        CPM_CLK_PERIPH = 3'h2,
        CPM_CLK_OSC = 3'h3,
        CPM_CLK_PRESCALE = 3'h4,
        CPM_CLK_POSTSCALE = 3'h5
    } cpm_clk_sel_e;
endpackage

// *** verification/cpm_clock_pin_mux_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpm_clock_pin_mux_monitor
    import cpm_pkg::*;
(
    // clock, reset, bus qualifiers
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    // oscillator and clock routing
    input wire logic clock_source_select_pin,
    input wire logic oscillator_out_pin_i,
    input wire logic oscillator_out_pin_oe,
    input wire logic input_clock,
    input wire logic core_clock_direct,
    input wire logic pll_ref_clock,
    input wire logic core_from_pll,
    input wire logic clock_monitor_out_oe,
    // external bus and ports
    input wire logic emi_bus_active,
    input wire logic [3:0] emi_ctrl_oe,
    input wire logic [cpm_pkg::CPM_PA_W-1:0] port_a_oe,
    input wire logic [cpm_pkg::CPM_PA_W-1:0] port_a_pullup_on,
    input wire logic [cpm_pkg::CPM_PB_W-1:0] port_b_oe,
    input wire logic [cpm_pkg::CPM_PB_W-1:0] port_b_pullup_on
);
    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // values seen just after a reset edge taken with ce high
    AST_RST_DRIVERS: assert property ($fell(rst) && $past(ce) |->
        port_a_oe == 6'h00 && port_b_oe == 4'h0 && !clock_monitor_out_oe
        && emi_ctrl_oe == 4'h0) else $error("drivers on after reset");
    AST_RST_PULLUPS: assert property ($fell(rst) && $past(ce) |->
        port_a_pullup_on == 6'h3f && port_b_pullup_on == 4'hf)
        else $error("pullups off after reset");
    // pullups move only one edge after a taken write
    AST_PULLUP_HOLD: assert property
        ((ce && !(hsel && htrans[1] && hwrite)) [*3] |=>
        $stable(port_a_pullup_on) && $stable(port_b_pullup_on))
        else $error("pullups changed without a write");
    // core and pll paths are exclusive copies of the input clock
    AST_CORE_DIRECT: assert property
        (core_clock_direct == (input_clock && !core_from_pll))
        else $error("direct core clock wrong");
    AST_PLL_REF: assert property
        (pll_ref_clock == (input_clock && core_from_pll))
        else $error("pll reference wrong");
    // four sampled cycles cover the synchronisers and output register
    AST_EXT_MODE: assert property
        ((clock_source_select_pin && oscillator_out_pin_i && ce) [*4] |=>
        input_clock && !oscillator_out_pin_oe)
        else $error("external clock not taken");
    AST_OSCILLATOR_OUT_PIN_MODE: assert property
        ((!clock_source_select_pin && ce) [*4] |=> oscillator_out_pin_oe)
        else $error("oscillator not driven");
    AST_EMI_ACTIVE: assert property
        (emi_bus_active && ce |=> emi_ctrl_oe == 4'hf)
        else $error("control lines released on an active bus");
    cover property (clock_monitor_out_oe && port_b_oe == 4'hf);
    cover property (emi_bus_active ##1 emi_ctrl_oe == 4'hf);
    cover property (core_from_pll && pll_ref_clock);
endmodule
`default_nettype wire

// *** verification/cpm_ext_world.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpm_ext_world (
    // board strap and source control
    input wire logic clock,
    input wire logic mode,
    input wire logic run,
    // oscillator pins
    input wire logic osc_o,
    input wire logic osc_oe,
    output logic osc_in,
    output logic osc_out_i,
    // shared port pins, port b above port a
    input wire logic [9:0] pin_o,
    input wire logic [9:0] pin_oe,
    input wire logic [9:0] pin_pu,
    output logic [9:0] pin_i
);
    logic [3:0] div_r = 4'h0;
    logic [9:0] last_r = 10'h000;
    logic src;
    // slow source and last pin levels for the floating model
    always_ff @(posedge clock) begin
        div_r <= div_r + 4'h1;
        last_r <= pin_i;
    end
    // parked high while stopped, so levels can be predicted
    assign src = run ? div_r[3] : 1'b1;
    // external mode grounds the in pin and drives the out pin
    assign osc_in = mode ? 1'b0 : src;
    assign osc_out_i = osc_oe ? osc_o : (mode ? src : ~osc_o);
    // a released pin floats to its pullup, else wanders every cycle
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & (pin_pu | ~last_r));
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cpm_pkg::*;
    logic clock, rst, ce, hsel, hwrite, hready, hreadyout, hresp, run, rd_dp;
    logic [31:0] haddr, hwdata, hrdata, pin_val;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic clock_source_select_pin, master_system_clock, peripheral_bus_clock;
    logic prescaler_clock, postscaler_clock, emi_bus_active, input_clock;
    logic [3:0] emi_addr_hi, emi_ctrl, emi_ctrl_o, emi_ctrl_oe;
    logic oscillator_out_pin_o, oscillator_out_pin_oe, core_from_pll;
    logic core_clock_direct, pll_ref_clock;
    logic clock_monitor_out, clock_monitor_out_oe;
    wire logic oscillator_in_pin, oscillator_out_pin_i;
    wire logic [5:0] port_a_i;
    wire logic [3:0] port_b_i;
    logic [5:0] port_a_o, port_a_oe, port_a_pullup_on;
    logic [3:0] port_b_o, port_b_oe, port_b_pullup_on;
    logic [31:0] exp_q[$];
    int error_cnt, checked;
    event pin_ev;
    // one slave, so its ready is the bus ready
    assign hready = hreadyout;
    cpm_clock_pin_mux dut (.*);
    // board clock source and pin loads
    cpm_ext_world ext (.clock, .mode(clock_source_select_pin), .run,
        .osc_o(oscillator_out_pin_o), .osc_oe(oscillator_out_pin_oe),
        .osc_in(oscillator_in_pin), .osc_out_i(oscillator_out_pin_i),
        .pin_o({port_b_o, port_a_o}), .pin_oe({port_b_oe, port_a_oe}),
        .pin_pu({port_b_pullup_on, port_a_pullup_on}),
        .pin_i({port_b_i, port_a_i}));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    // read data is judged at the edge that ends its data phase
    always @(posedge clock) begin
        if (rd_dp === 1'b1)
            check(hrdata, exp_q.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hready;
    end
    // pin observations are judged in the order they were noted
    always @(pin_ev)
        check(pin_val, exp_q.pop_front());
    task automatic bus(input logic [7:0] a, input logic w,
            input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clock);
        while (hready !== 1'b1)
            @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hready !== 1'b1)
            @(posedge clock);
    endtask
    // outputs follow three edges after a cause; look mid-cycle after four
    task automatic settle;
        repeat (4)
            @(posedge clock);
        @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        settle();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h00000000);
        @(negedge clock); // read note leaves the queue before pin notes
    endtask
    task automatic look(input logic [31:0] seen, input logic [31:0] e);
        exp_q.push_back(e);
        pin_val = seen;
        -> pin_ev;
        #1;
    endtask
    task automatic summarize;
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000)
            @(posedge clock);
        error_cnt++;
        summarize();
    end
    initial begin
        logic [31:0] v, x, d;
        logic lvl;
        int code;
        void'($urandom(56194));
        {rst, ce, hsel, hwrite, run} = 5'h18;
        error_cnt = 0;
        checked = 0;
        {haddr, hwdata, htrans, hsize} = 69'h2;
        {clock_source_select_pin, master_system_clock} = 2'h2;
        {peripheral_bus_clock, prescaler_clock, postscaler_clock} = 3'h0;
        {emi_bus_active, emi_addr_hi, emi_ctrl} = 9'h0a5;
        repeat (20)
            @(posedge clock);
        rst <= 1'b0;
        rd(CPM_PA_PULLUP_OFF, 32'h3f);
        rd(CPM_PB_PULLUP_OFF, 32'hf);
        rd(CPM_PA_GPIO_EN_OFF, 32'h0);
        rd(CPM_PB_PERIPH_EN_OFF, 32'hf);
        rd(CPM_BUS_CTRL_OFF, 32'h0);
        rd(8'hfc, 32'h0);
        look({port_a_oe, port_b_oe, clock_monitor_out_oe}, 32'h0);
        look({oscillator_out_pin_oe, input_clock}, 32'h1);
        look({hresp, hreadyout, emi_ctrl_o}, 32'h15);
        rd(CPM_CLK_CTRL_OFF, 32'h2);
        wr(CPM_CLK_CTRL_OFF, 32'h1);
        look({core_clock_direct, pll_ref_clock, core_from_pll}, 32'h3);
        wr(CPM_CLK_CTRL_OFF, 32'h0);
        look({core_clock_direct, pll_ref_clock, core_from_pll}, 32'h4);
        // every select code, internal clocks parked at random levels
        for (code = 0; code < 8; code++) begin
            v = $urandom;
            @(posedge clock);
            {master_system_clock, peripheral_bus_clock} <= v[1:0];
            {prescaler_clock, postscaler_clock} <= v[3:2];
            case (code)
                1: lvl = v[1];
                2: lvl = v[0];
                3: lvl = 1'b1;
                4: lvl = v[3];
                5: lvl = v[2];
                default: lvl = 1'b0;
            endcase
            wr(CPM_CLK_OUT_SEL_OFF, 32'(code));
            look({clock_monitor_out_oe, clock_monitor_out},
                {code inside {[1:5]}, lvl});
        end
        v = $urandom;
        wr(CPM_PA_PULLUP_OFF, {26'h0, v[5:0]});
        look(port_a_pullup_on, v[5:0]);
        wr(CPM_PB_PULLUP_OFF, {28'h0, v[9:6]});
        look(port_b_pullup_on, v[9:6]);
        rd(CPM_PA_PULLUP_OFF, {26'h0, v[5:0]});
        wr(CPM_PA_PULLUP_OFF, 32'h3f);
        x = $urandom;
        d = $urandom | 32'h1;
        wr(CPM_PA_DATA_OFF, x);
        wr(CPM_PA_DIR_OFF, d);
        look(port_a_oe, 32'h0);
        wr(CPM_PA_GPIO_EN_OFF, 32'h3f);
        look({port_a_oe, port_a_o}, {d[5:0], x[5:0]});
        rd(CPM_PA_PIN_OFF, {26'h0, (x[5:0] & d[5:0]) | ~d[5:0]});
        wr(CPM_PB_DIR_OFF, 32'hf);
        wr(CPM_PB_DATA_OFF, {28'h0, x[9:6]});
        look({port_b_oe, port_b_o}, {4'hf, x[9:6]});
        rd(CPM_PB_PIN_OFF, {28'h0, x[9:6]});
        // hand port b to the address lines, bus idle then active
        @(posedge clock);
        emi_addr_hi <= d[3:0];
        wr(CPM_PB_PERIPH_EN_OFF, 32'h0);
        look({port_b_oe, emi_ctrl_oe}, 32'h0);
        @(posedge clock);
        emi_bus_active <= 1'b1;
        settle();
        look({port_b_oe, port_b_o, emi_ctrl_oe}, {8'hf0 | d[3:0], 4'hf});
        @(posedge clock);
        emi_bus_active <= 1'b0;
        master_system_clock <= 1'b1;
        wr(CPM_BUS_CTRL_OFF, 32'h1);
        look({port_b_oe, emi_ctrl_oe}, 32'hff);
        wr(CPM_CLK_OUT_SEL_OFF, 32'h11);
        look({port_b_oe, port_b_o}, 32'hff);
        // enable low: the monitor must hold its level though the source drops
        @(posedge clock);
        ce <= 1'b0;
        master_system_clock <= 1'b0;
        settle();
        look({port_b_o, clock_monitor_out}, 32'h1f);
        @(posedge clock);
        ce <= 1'b1;
        @(posedge clock);
        clock_source_select_pin <= 1'b0;
        settle();
        look({oscillator_out_pin_oe, oscillator_out_pin_o}, 32'h2);
        rd(CPM_CLK_CTRL_OFF, 32'h0);
        @(posedge clock);
        run <= 1'b1;
        emi_bus_active <= 1'b1;
        // second reset in mid-run with drivers and monitor active
        @(posedge clock);
        rst <= 1'b1;
        repeat (2)
            @(posedge clock);
        @(negedge clock);
        look({port_a_oe, port_b_oe, clock_monitor_out_oe, emi_ctrl_oe,
            port_a_pullup_on, port_b_pullup_on}, {15'h0000, 10'h3ff});
        @(posedge clock);
        rst <= 1'b0;
        rd(CPM_PA_PULLUP_OFF, 32'h3f);
        rd(CPM_PB_PERIPH_EN_OFF, 32'hf);
        summarize();
    end
endmodule
bind cpm_clock_pin_mux cpm_clock_pin_mux_monitor mon (.clock, .rst, .ce,
    .hsel, .htrans, .hwrite, .clock_source_select_pin, .oscillator_out_pin_i,
    .oscillator_out_pin_oe, .input_clock, .core_clock_direct, .pll_ref_clock,
    .core_from_pll, .clock_monitor_out_oe, .emi_bus_active, .emi_ctrl_oe,
    .port_a_oe, .port_a_pullup_on, .port_b_oe, .port_b_pullup_on);
`default_nettype wire
